// [iord_decoder.sv]
//
// Function
// - With expanded space off and no remaps, on-chip selection compares only address bits 9..0.
// - In legacy mode the legacy peripherals answer at slot 0 and all others stay silent.
// - With expanded space off and some remaps, decoding stays ten-bit and remapped or non-legacy units stay silent.
// - With expanded space on, all sixteen bits decode and legacy units also answer inside slot 0.
// - A slot 0 legacy access reaches the same register that lives in slot 15.
// - With expanded space on, a remapped legacy unit answers only at its slot 15 address.
// - Every unit except the remap register lives in the three slot 15 windows F0xx, F4xx, F8xx.
// - Slot 0 and slot 15 addresses share ten low bits, or eight for the serial channels.
// - Serial channels have fixed addresses, channel 0 at F4F8H to F4FFH.
// - Interconnect and pin configuration registers decode at F820H to F83FH.
// - Timer one output can drive slave request line two, and its pin can carry a port line.
// - The expanded-space enable is bit 15 of the remap register, set by unlock and readable.
// - The expanded space opens only after the unlock write sequence to 22H and 23H.
// - Clearing the enable closes expanded space and locks the remap register read-only.
// - Reset clears the remap register to legacy mode.
//
`timescale 1ns/1ps
module iord_decoder
	import iord_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	// Processor I/O cycle
	input wire logic io_req_i,
	input wire logic io_we_i,
	input wire logic [IO_AW-1:0] io_addr_i,
	input wire logic [IO_DW-1:0] io_wdata_i,
	output logic [N_PERIPH-1:0] periph_sel_o,
	output logic cfg_port_sel_o,
	output logic internal_claim_o,
	output logic external_claim_o,
	output logic [IO_DW-1:0] cfg_rdata_o,
	output logic expanded_space_enable_o,
	// Module interconnect and shared pin
	input wire logic timer_one_out_i,
	input wire logic parallel_port_three_line_one_i,
	input wire logic ext_request_line_two_i,
	output logic slave_request_line_two_o,
	output logic timer_one_output_pin_o,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [WB_AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [WB_DW-1:0] wb_dat_i,
	output logic [WB_DW-1:0] wb_dat_o,
	output logic wb_ack_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [15:0] address_remap_config;
	logic [1:0] iconn;
	logic [N_PERIPH-1:0] last_sel;
	logic last_internal;

	wire expanded_space_enable;
	wire [N_PERIPH-1:0] hit;
	wire cfg_lo;
	wire cfg_hi;
	wire cfg_hit;
	wire io_wr;
	wire unlock;
	wire remap_wr;
	wire iconn_io_wr;
	wire any_hit;
	wire wb_req;
	wire wb_iconn_wr;
	wire [WB_DW-1:0] wb_rdata;
	wire next_route;
	wire next_pin;

	assign expanded_space_enable = address_remap_config[ESE_BIT];

	// ----------------------------------------------------------------
	// Per-unit address match
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < N_PERIPH; g++)
		begin : g_match
			iord_match #(
				.BASE(P_BASE[g]),
				.MASK(P_MASK[g]),
				.LEGACY_BASE(P_LEGACY[g]),
				.IS_LEGACY(P_IS_LEGACY[g])
			) u_match (
				.addr_i(io_addr_i),
				.ese_i(expanded_space_enable),
				.remapped_i(address_remap_config[P_REMAP[g]]),
				.hit_o(hit[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Configuration port, ten-bit aliased into every slot when closed, in slot 0 only when open
	// ----------------------------------------------------------------
	assign cfg_lo = (io_addr_i[9:0] == CFG_PORT_LO) && (!expanded_space_enable || io_addr_i[15:10] == 6'h00);
	assign cfg_hi = (io_addr_i[9:0] == CFG_PORT_HI) && (!expanded_space_enable || io_addr_i[15:10] == 6'h00);
	assign cfg_hit = cfg_lo || cfg_hi;
	assign io_wr = io_req_i && io_we_i;

	iord_unlock u_unlock (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_i(io_wr),
		.port_lo_i(cfg_lo),
		.port_hi_i(cfg_hi),
		.unlock_o(unlock)
	);

	// Write-protected while closed; the finishing unlock write carries no data
	assign remap_wr = io_wr && cfg_lo && expanded_space_enable;
	// Interconnect word decodes only through the chip configuration window
	assign iconn_io_wr = io_wr && expanded_space_enable && (io_addr_i == ICONN_IO_ADDR) && hit[13];

	// Unclaimed cycles go out; external logic owns full decode when open
	assign any_hit = (|hit) || cfg_hit;

	// ----------------------------------------------------------------
	// Remap configuration register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			address_remap_config <= REMAP_RESET;
		else if (unlock)
			address_remap_config[ESE_BIT] <= 1'b1;
		else if (remap_wr)
			address_remap_config <= (io_wdata_i & (REMAP_WR_MASK | (16'h0001 << ESE_BIT)));
	end

	// ----------------------------------------------------------------
	// Decode outputs, one cycle after the request
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			periph_sel_o <= '0;
			cfg_port_sel_o <= 1'b0;
			internal_claim_o <= 1'b0;
			external_claim_o <= 1'b0;
			last_sel <= '0;
			last_internal <= 1'b0;
		end
		else
		begin
			periph_sel_o <= io_req_i ? hit : '0;
			cfg_port_sel_o <= io_req_i && cfg_hit;
			internal_claim_o <= io_req_i && any_hit;
			external_claim_o <= io_req_i && !any_hit;
			if (io_req_i)
			begin
				last_sel <= hit;
				last_internal <= any_hit;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cfg_rdata_o <= REMAP_RESET;
			expanded_space_enable_o <= 1'b0;
		end
		else
		begin
			cfg_rdata_o <= address_remap_config;
			expanded_space_enable_o <= expanded_space_enable;
		end
	end

	// ----------------------------------------------------------------
	// Interconnect and pin function
	// ----------------------------------------------------------------
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_iconn_wr = wb_req && wb_we_i && (wb_adr_i == WB_ICONN_OFS) && wb_sel_i[0];

	// Processor I/O write wins a same-cycle collision
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			iconn <= ICONN_RESET;
		else if (iconn_io_wr)
			iconn <= io_wdata_i[1:0];
		else if (wb_iconn_wr)
			iconn <= wb_dat_i[1:0];
	end

	// Request line falls back to the external source when not routed
	assign next_route = iconn[ICONN_ROUTE_BIT] ? timer_one_out_i : ext_request_line_two_i;
	assign next_pin = iconn[ICONN_PIN_BIT] ? parallel_port_three_line_one_i : timer_one_out_i;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			slave_request_line_two_o <= 1'b0;
			timer_one_output_pin_o <= 1'b0;
		end
		else
		begin
			slave_request_line_two_o <= next_route;
			timer_one_output_pin_o <= next_pin;
		end
	end

	// ----------------------------------------------------------------
	// Wishbone slave, ack one cycle after strobe
	// ----------------------------------------------------------------
	// Unmapped offsets still ack, read zero, and drop writes
	assign wb_rdata = (wb_adr_i == WB_REMAP_OFS) ? {16'h0000, address_remap_config} :
		(wb_adr_i == WB_ICONN_OFS) ? {30'h00000000, iconn} :
		(wb_adr_i == WB_STATUS_OFS) ? {15'h0000, last_internal, last_sel} :
		32'h00000000;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end
		else
		begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? wb_rdata : '0;
		end
	end

endmodule

// [iord_pkg.sv]
package iord_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int IO_AW = 16;
	localparam int IO_DW = 16;
	localparam int N_PERIPH = 16;
	localparam int WB_AW = 8;
	localparam int WB_DW = 32;

	// ----------------------------------------------------------------
	// Remap configuration register layout
	// ----------------------------------------------------------------
	localparam int ESE_BIT = 15;
	localparam int TMR_REMAP_BIT = 1;
	localparam int DMA_REMAP_BIT = 2;
	localparam int MPIC_REMAP_BIT = 3;
	localparam int SPIC_REMAP_BIT = 4;
	localparam int SIO0_REMAP_BIT = 5;
	localparam int SIO1_REMAP_BIT = 6;
	localparam logic [15:0] REMAP_WR_MASK = 16'h007E;
	localparam logic [15:0] REMAP_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// Configuration port and interconnect register I/O addresses
	// ----------------------------------------------------------------
	localparam logic [9:0] CFG_PORT_LO = 10'h022;
	localparam logic [9:0] CFG_PORT_HI = 10'h023;
	localparam logic [15:0] ICONN_IO_ADDR = 16'hF820;
	localparam int ICONN_ROUTE_BIT = 0;
	localparam int ICONN_PIN_BIT = 1;
	localparam logic [1:0] ICONN_RESET = 2'h0;

	// ----------------------------------------------------------------
	// Wishbone register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] WB_REMAP_OFS = 8'h00;
	localparam logic [7:0] WB_ICONN_OFS = 8'h04;
	localparam logic [7:0] WB_STATUS_OFS = 8'h08;

	// ----------------------------------------------------------------
	// Peripheral map: slot 15 base, size mask, slot 0 alias, remap bit
	// ----------------------------------------------------------------
	localparam logic [15:0] P_BASE [N_PERIPH] = '{
		16'hF000, 16'hF020, 16'hF040, 16'hF080, 16'hF0A0, 16'hF0F0,
		16'hF400, 16'hF480, 16'hF4A0, 16'hF4C0, 16'hF4F8,
		16'hF800, 16'hF810, 16'hF820, 16'hF860, 16'hF8F8};
	localparam logic [15:0] P_MASK [N_PERIPH] = '{
		16'h001F, 16'h001F, 16'h001F, 16'h001F, 16'h001F, 16'h000F,
		16'h007F, 16'h001F, 16'h001F, 16'h000F, 16'h0007,
		16'h000F, 16'h000F, 16'h001F, 16'h001F, 16'h0007};
	localparam logic [9:0] P_LEGACY [N_PERIPH] = '{
		10'h000, 10'h020, 10'h040, 10'h080, 10'h0A0, 10'h000,
		10'h000, 10'h000, 10'h000, 10'h000, 10'h3F8,
		10'h000, 10'h000, 10'h000, 10'h000, 10'h2F8};
	localparam logic [N_PERIPH-1:0] P_IS_LEGACY = 16'h841F;
	localparam int P_REMAP [N_PERIPH] = '{
		DMA_REMAP_BIT, MPIC_REMAP_BIT, TMR_REMAP_BIT, DMA_REMAP_BIT,
		SPIC_REMAP_BIT, 0, 0, 0, 0, 0, SIO0_REMAP_BIT,
		0, 0, 0, 0, SIO1_REMAP_BIT};

endpackage

// [iord_match.sv]
`timescale 1ns/1ps
module iord_match
	import iord_pkg::*;
#(
	parameter logic [15:0] BASE = 16'hF000,
	parameter logic [15:0] MASK = 16'h001F,
	parameter logic [9:0] LEGACY_BASE = 10'h000,
	parameter logic IS_LEGACY = 1'b0
)
(
	input wire logic [IO_AW-1:0] addr_i,
	input wire logic ese_i,
	input wire logic remapped_i,
	output logic hit_o
);

	wire exp_hit;
	wire low_hit;
	wire slot0_hit;

	// Physical home always in slot 15, reachable only when expanded
	assign exp_hit = ese_i && ((addr_i & ~MASK) == BASE);
	// Low ten bits of alias equal the slot 15 ones, only the low eight for the serial channels
	assign low_hit = ((addr_i[9:0] & ~MASK[9:0]) == LEGACY_BASE);
	// Ten-bit decode when closed, full sixteen inside slot 0 when open
	assign slot0_hit = IS_LEGACY && !remapped_i && low_hit
		&& (!ese_i || (addr_i[15:10] == 6'h00));
	// Both views select the same register
	assign hit_o = exp_hit || slot0_hit;

endmodule

// [iord_unlock.sv]
`timescale 1ns/1ps
module iord_unlock
	import iord_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wr_i,
	input wire logic port_lo_i,
	input wire logic port_hi_i,
	output logic unlock_o
);

	typedef enum logic [1:0]
	{
		UL_IDLE = 2'b00,
		UL_SAW_LO = 2'b01,
		UL_SAW_HI = 2'b10
	} iord_ul_t;

	iord_ul_t state;
	iord_ul_t next_state;
	logic next_unlock;

	// ----------------------------------------------------------------
	// Write sequence 22H, 23H, 22H; any other write restarts it
	// ----------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_unlock = 1'b0;
		if (wr_i)
		begin
			unique case (state)
				UL_IDLE: next_state = port_lo_i ? UL_SAW_LO : UL_IDLE;
				UL_SAW_LO: next_state = port_hi_i ? UL_SAW_HI : (port_lo_i ? UL_SAW_LO : UL_IDLE);
				UL_SAW_HI:
				begin
					next_unlock = port_lo_i;
					next_state = UL_IDLE;
				end
				default: next_state = UL_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state <= UL_IDLE;
			unlock_o <= 1'b0;
		end
		else
		begin
			state <= next_state;
			unlock_o <= next_unlock;
		end
	end

endmodule

// [iord_properties.sv]
`timescale 1ns/1ps
module iord_properties
	import iord_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic io_req_i,
	input wire logic [IO_AW-1:0] io_addr_i,
	input wire logic [N_PERIPH-1:0] periph_sel_o,
	input wire logic cfg_port_sel_o,
	input wire logic internal_claim_o,
	input wire logic external_claim_o,
	input wire logic [IO_DW-1:0] cfg_rdata_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Remap stable across the decode, so mode transitions are skipped
	a_claim_split:
		assert property (io_req_i |=> internal_claim_o != external_claim_o
			&& internal_claim_o == (|periph_sel_o || cfg_port_sel_o)) else $error("claim split");
	a_idle_quiet:
		assert property (!io_req_i |=> !internal_claim_o && !external_claim_o)
			else $error("claim without cycle");
	a_timer_slot0:
		assert property ($past(io_req_i) && $stable(cfg_rdata_o) && !cfg_rdata_o[1]
			&& $past(io_addr_i[9:5]) == 5'h02 && (!cfg_rdata_o[15]
			|| $past(io_addr_i[15:10]) == 6'h00) |-> periph_sel_o[2]) else $error("timer miss");
	a_timer_hidden:
		assert property ($past(io_req_i) && $stable(cfg_rdata_o) && cfg_rdata_o[1]
			&& $past(io_addr_i[15:10]) == 6'h00 |-> !periph_sel_o[2]) else $error("timer seen");
	a_legacy_only:
		assert property ($stable(cfg_rdata_o) && !cfg_rdata_o[15]
			|-> (periph_sel_o & ~P_IS_LEGACY) == 16'h0000) else $error("non-legacy seen");
	a_serial_fixed:
		assert property ($past(io_req_i) && $stable(cfg_rdata_o) && cfg_rdata_o[15]
			&& $past(io_addr_i[15:3]) == 13'h1E9F |-> periph_sel_o[10]) else $error("serial miss");
	a_iconn_window:
		assert property ($past(io_req_i) && $stable(cfg_rdata_o) && cfg_rdata_o[15]
			&& $past(io_addr_i[15:5]) == 11'h7C1 |-> periph_sel_o[13]) else $error("iconn miss");
	a_cfg_port:
		assert property ($past(io_req_i) && $stable(cfg_rdata_o) && !cfg_rdata_o[15]
			&& $past(io_addr_i[9:1]) == 9'h011 |-> cfg_port_sel_o) else $error("port miss");
	a_ack_pulse:
		assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
			else $error("ack timing");
endmodule

// [iord_ext_io.sv]
`timescale 1ns/1ps
module iord_ext_io #(
	parameter logic [15:0] BASE = 16'h0040
)
(
	input wire logic clk_i,
	input wire logic [15:0] addr_i,
	input wire logic req_i,
	input wire logic ext_claim_i,
	output logic ack_o
);
	logic [15:0] held;
	always_ff @(posedge clk_i)
		if (req_i)
			held <= addr_i;
	// Full 16-bit compare, no aliasing into slot 15
	assign ack_o = ext_claim_i && held == BASE;
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top
	import iord_pkg::*;
;
	logic clk_i = 0, rst_i = 1, io_req_i = 0, io_we_i = 0, t1 = 0, p31 = 0, rq2 = 0;
	logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, ext_ack, srl2, tpin, wb_ack_o;
	logic [15:0] io_addr_i = 0, io_wdata_i = 0, rm = 0, d, periph_sel_o, cfg_rdata_o;
	logic [7:0] wb_adr_i = 0;
	logic [3:0] wb_sel_i = 0;
	logic [31:0] wb_dat_i = 0, rd, seed = 32'h1987E45A, wb_dat_o, last_status = 0;
	logic cfg_port_sel_o, internal_claim_o, external_claim_o, expanded_space_enable_o;
	logic [15:0] corner [6] = '{16'h0040, 16'hFC47, 16'h03F8, 16'hF4FF, 16'hF83F, 16'h02FF};
	int fails = 0, checks_done = 0, cyc = 0;
	iord_decoder dut (.clk_i, .rst_i, .io_req_i, .io_we_i, .io_addr_i, .io_wdata_i,
		.periph_sel_o, .cfg_port_sel_o, .internal_claim_o, .external_claim_o, .cfg_rdata_o,
		.expanded_space_enable_o, .timer_one_out_i(t1), .parallel_port_three_line_one_i(p31),
		.ext_request_line_two_i(rq2), .slave_request_line_two_o(srl2),
		.timer_one_output_pin_o(tpin), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o);
	iord_ext_io ext (.clk_i, .addr_i(io_addr_i), .req_i(io_req_i),
		.ext_claim_i(external_claim_o), .ack_o(ext_ack));
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			give_verdict();
		end
	end
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] exp_sel(logic [15:0] a);
		for (int i = 0; i < N_PERIPH; i++)
			exp_sel[i] = rm[15] && (a & ~P_MASK[i]) == P_BASE[i] || P_IS_LEGACY[i]
				&& !rm[P_REMAP[i]] && (!rm[15] || a[15:10] == 6'h00)
				&& (a[9:0] & ~P_MASK[i][9:0]) == P_LEGACY[i];
	endfunction
	task automatic check(string n, logic [31:0] s, logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic io(logic [15:0] a, logic w, logic [15:0] dd);
		logic [15:0] es;
		logic cp;
		es = exp_sel(a);
		cp = rm[15] ? a[15:1] == 15'h0011 : a[9:1] == 9'h011;
		io_addr_i <= a;
		io_we_i <= w;
		io_wdata_i <= dd;
		io_req_i <= 1'b1;
		last_status = {15'h0000, es != 16'h0000 || cp, es};
		@(posedge clk_i);
		io_req_i <= 1'b0;
		// Registered answer is settled at the following edge
		@(posedge clk_i);
		check("sel", periph_sel_o, es);
		check("ext", external_claim_o, es == 0 && !cp);
		check("ext_ack", ext_ack, es == 0 && !cp && a == 16'h0040);
	endtask
	task automatic wb(logic w, logic [7:0] ad, logic [31:0] dd);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= ad;
		wb_dat_i <= dd;
		wb_sel_i <= 4'hF;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1)
			@(posedge clk_i);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic sweep();
		foreach (corner[i])
			io(corner[i], 1'b0, 16'h0000);
		repeat (60)
			io(xs() & (seed[20] ? 16'hFFFF : 16'h03FF), 1'b0, 16'h0000);
		repeat (3) @(posedge clk_i);
		check("rdata", cfg_rdata_o, rm);
		check("ese", expanded_space_enable_o, rm[15]);
		wb(1'b0, WB_STATUS_OFS, 32'h0);
		check("status", rd, last_status);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		sweep();
		io(16'h0022, 1'b1, 16'h807E);
		io(16'h0023, 1'b1, 16'h0000);
		io(16'h0023, 1'b1, 16'h0000);
		sweep();
		for (int i = 0; i < 5; i++)
		begin
			io(16'h0022, 1'b1, 16'h0000);
			// An open register stores the zero data of the first step
			rm = rm[15] ? 16'h0000 : rm;
			io(16'h0023, 1'b1, 16'h0000);
			io(16'h0022, 1'b1, 16'h0000);
			rm[15] = 1'b1;
			sweep();
			d = i == 0 ? 16'h8000 : i == 1 ? 16'hFFFF : xs() | 16'h8000;
			d = i == 4 ? d & 16'h7FFF : d;
			// Decode of the write cycle itself still sees the old value
			io(16'h0022, 1'b1, d);
			rm = d & 16'h807E;
			sweep();
			wb(1'b1, WB_REMAP_OFS, 32'h0000FFFF);
			wb(1'b0, WB_REMAP_OFS, 32'h0);
			check("remap_rd", rd, {16'h0000, rm});
		end
		io(16'h0022, 1'b1, 16'h807E);
		sweep();
		wb(1'b0, 8'h0C, 32'h0);
		check("unmapped", rd, 32'h0);
		for (int k = 0; k < 4; k++)
		begin
			wb(1'b1, WB_ICONN_OFS, k);
			wb(1'b0, WB_ICONN_OFS, 32'h0);
			check("iconn", rd, k);
			repeat (6)
			begin
				{t1, p31, rq2} <= xs();
				repeat (2) @(posedge clk_i);
				check("req2", srl2, k[0] ? t1 : rq2);
				check("pin", tpin, k[1] ? p31 : t1);
			end
		end
		give_verdict();
	end
endmodule
bind iord_decoder iord_properties chk (.clk_i, .rst_i, .io_req_i, .io_addr_i, .periph_sel_o,
	.cfg_port_sel_o, .internal_claim_o, .external_claim_o, .cfg_rdata_o, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o);
